// ==== core/wdf_params.svh ====
`ifndef WDF_PARAMS_SVH
`define WDF_PARAMS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define WDF_ADDR_CTRL     8'h00
`define WDF_ADDR_STATUS   8'h04
`define WDF_ADDR_DATA     8'h08
`define WDF_ADDR_IRQ_STAT 8'h0c
`define WDF_ADDR_IRQ_MASK 8'h10
// ****************************************
// Field positions and reset values
// ****************************************
`define WDF_CTRL_LOWLAT   0
`define WDF_CTRL_RATIO    1
`define WDF_CTRL_SPEED    4
`define WDF_CTRL_BUFEN    5
`define WDF_CTRL_SYNC     6
`define WDF_CTRL_RST      6'h00
`define WDF_ST_READY      0
`define WDF_ST_SAT        1
`define WDF_ST_BUSY       2
`define WDF_IRQ_DATA      0
`define WDF_IRQ_SAT       1
`define WDF_IRQ_RST       2'h0
// ****************************************
// Timing
// ****************************************
`define WDF_MCLK_NS       10
`define WDF_OVH_NS        400
`define WDF_OVH_CYC       ((`WDF_OVH_NS + `WDF_MCLK_NS - 1) / `WDF_MCLK_NS)
`define WDF_BUF_CONV      8
`define WDF_NCO_HS        24'h418937
`define WDF_NCO_LS        24'h083127
`define WDF_FIR_TAPS      69
`define WDF_SUPPRESS      68
`define WDF_RECIP         950
`define WDF_RECIP_SH      16
`endif

// ==== core/wdf_pkg.sv ====
package wdf_pkg;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_OVH = 3'b001,
    ST_BUF = 3'b010,
    ST_RUN = 3'b100
  } wdf_state_e;

  typedef struct packed {
    logic       bufen;
    logic       low_speed;
    logic [2:0] ratio;
    logic       low_lat;
  } wdf_cfg_s;

  typedef logic signed [15:0] wdf_word_t;

  // Ratio code 0..7 selects 32..4096; returns the ratio minus one.
  function automatic logic [11:0] wdf_osr_last(input logic [2:0] code);
    wdf_osr_last = 12'(({13'h0020} << code) - 13'h0001);
  endfunction
endpackage

// ==== core/wdf_decim.sv ====
`include "wdf_params.svh"
module wdf_decim
  import wdf_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_b,
  // Control
  input  wire logic            clr,
  input  wire logic [2:0]      ratio,
  // Modulator samples
  input  wire logic            mod_en,
  input  wire logic [4:0]      sample,
  // Decimated words
  output wdf_word_t            word,
  output logic                 word_valid
);
  logic [11:0]        cnt_r, cnt_nxt;
  logic signed [16:0] acc_r, acc_nxt;
  logic signed [16:0] sum;
  logic signed [16:0] scaled;
  wdf_word_t          word_nxt;
  logic               val_nxt;

  // ****************************************
  // Accumulate and dump over one ratio period
  // ****************************************
  always_comb begin
    sum      = acc_r + 17'(signed'(sample));
    scaled   = sum <<< (3'd7 - ratio);
    cnt_nxt  = cnt_r;
    acc_nxt  = acc_r;
    word_nxt = word;
    val_nxt  = 1'b0;
    if (clr) begin
      cnt_nxt = 12'h000;
      acc_nxt = 17'sh00000;
    end else if (mod_en) begin
      if (cnt_r == wdf_osr_last(ratio)) begin
        cnt_nxt  = 12'h000;
        acc_nxt  = 17'sh00000;
        word_nxt = scaled[16:1];
        val_nxt  = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 12'h001;
        acc_nxt = sum;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= 12'h000;
      acc_r      <= 17'sh00000;
      word       <= 16'sh0000;
      word_valid <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      acc_r      <= acc_nxt;
      word       <= word_nxt;
      word_valid <= val_nxt;
    end
  end
endmodule

// ==== core/wdf_top.sv ====
// Our own choices: the APB register port and the register offsets.
`include "wdf_params.svh"
module wdf_top
  import wdf_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Modulator side
  input  wire logic [4:0]  mod_data,
  input  wire logic        mod_sat,
  input  wire logic        sync_pin,
  output logic             mod_clk_o,
  // Conversion output
  output wdf_word_t        data_word,
  output logic             conversion_ready_n,
  output logic             modulator_saturation_flag,
  output logic             irq
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [4:0]  mdat_m_r, mdat_s_r;
  logic        msat_m_r, msat_s_r;
  logic        sync_m_r, sync_s_r, sync_d_r;
  logic [23:0] nco_r, nco_nxt;
  logic        conv_tick;
  logic        mod_ph_r, mod_ph_nxt;
  logic        mod_en;
  wdf_cfg_s    ctrl_r, ctrl_nxt, cfg_r, cfg_nxt;
  wdf_state_e  st_r, st_nxt;
  logic [7:0]  ovh_r, ovh_nxt;
  logic [3:0]  bufc_r, bufc_nxt;
  logic        acc_wr, acc_rd, wr_ctrl, rd_data, rd_irq;
  logic        restart;
  logic        run;
  wdf_word_t   dword;
  logic        dvalid;
  wdf_word_t   tap_mem [0:`WDF_FIR_TAPS-1];
  logic [6:0]  ptr_r, ptr_nxt;
  logic [6:0]  fill_r, fill_nxt;
  logic signed [22:0] fsum_r, fsum_nxt;
  wdf_word_t   oldest;
  logic        pub;
  wdf_word_t   pub_val;
  logic        sat_acc_r, sat_acc_nxt;
  logic        sat_flag_nxt;
  logic        conversion_ready_n_nxt, pend_r, pend_nxt;
  wdf_word_t   pval_r, pval_nxt, data_nxt;
  logic [1:0]  istat_r, istat_nxt, imask_r, imask_nxt;
  logic [1:0]  iev;

  // Scales a full 69-word sum back to one word and clips it.
  function automatic wdf_word_t wdf_norm(input logic signed [22:0] s);
    logic signed [33:0] p;
    p = (34'(s) * 34'sd`WDF_RECIP) >>> `WDF_RECIP_SH;
    if (p > 34'sh0_0000_7fff) wdf_norm = 16'sh7fff;
    else if (p < -34'sh0_0000_8000) wdf_norm = 16'sh8000;
    else wdf_norm = p[15:0];
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mdat_m_r <= 5'h00;
      mdat_s_r <= 5'h00;
      msat_m_r <= 1'b0;
      msat_s_r <= 1'b0;
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      mdat_m_r <= mod_data;
      mdat_s_r <= mdat_m_r;
      msat_m_r <= mod_sat;
      msat_s_r <= msat_m_r;
      sync_m_r <= sync_pin;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end

  // ****************************************
  // Converter and modulator clock enables
  // ****************************************
  // A phase accumulator is used because 100 MHz has no integer
  // divisor to 25.6 MHz; ticks jitter by one mclk but average exact.
  always_comb begin
    {conv_tick, nco_nxt} = {1'b0, nco_r} +
      {1'b0, cfg_r.low_speed ? `WDF_NCO_LS : `WDF_NCO_HS};
    mod_ph_nxt = conv_tick ? ~mod_ph_r : mod_ph_r;
    mod_en     = conv_tick & mod_ph_r;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nco_r    <= 24'h000000;
      mod_ph_r <= 1'b0;
    end else begin
      nco_r    <= nco_nxt;
      mod_ph_r <= mod_ph_nxt;
    end
  end

  assign mod_clk_o = mod_ph_r;

  // ****************************************
  // APB decode
  // ****************************************
  assign pready  = 1'b1;
  assign acc_wr  = psel & penable & pwrite;
  assign acc_rd  = psel & penable & ~pwrite;
  assign wr_ctrl = acc_wr & (paddr == `WDF_ADDR_CTRL);
  assign rd_data = acc_rd & (paddr == `WDF_ADDR_DATA);
  assign rd_irq  = acc_rd & (paddr == `WDF_ADDR_IRQ_STAT);

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `WDF_ADDR_CTRL: prdata[5:0] = {ctrl_r.bufen, ctrl_r.low_speed,
                                     ctrl_r.ratio, ctrl_r.low_lat};
      `WDF_ADDR_STATUS: begin
        prdata[`WDF_ST_READY] = ~conversion_ready_n;
        prdata[`WDF_ST_SAT]   = modulator_saturation_flag;
        prdata[`WDF_ST_BUSY]  = (st_r != ST_RUN);
      end
      `WDF_ADDR_DATA:     prdata[15:0] = data_word;
      `WDF_ADDR_IRQ_STAT: prdata[1:0]  = istat_r;
      `WDF_ADDR_IRQ_MASK: prdata[1:0]  = imask_r;
      default:            pslverr = psel & penable;
    endcase
  end

  // ****************************************
  // Configuration and restart sequencing
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.low_lat   = pwdata[`WDF_CTRL_LOWLAT];
      ctrl_nxt.ratio     = pwdata[`WDF_CTRL_RATIO +: 3];
      ctrl_nxt.low_speed = pwdata[`WDF_CTRL_SPEED];
      ctrl_nxt.bufen     = pwdata[`WDF_CTRL_BUFEN];
    end
    // A new setting never reaches a running filter directly.
    restart = (sync_s_r & ~sync_d_r) |
              (wr_ctrl & (pwdata[`WDF_CTRL_SYNC] | (ctrl_nxt != ctrl_r)));
    cfg_nxt  = restart ? ctrl_nxt : cfg_r;
    st_nxt   = st_r;
    ovh_nxt  = ovh_r;
    bufc_nxt = bufc_r;
    if (restart) begin
      st_nxt  = ST_OVH;
      ovh_nxt = 8'(`WDF_OVH_CYC - 1);
    end else begin
      case (st_r)
        ST_OVH: begin
          if (ovh_r != 8'h00) begin
            ovh_nxt = ovh_r - 8'h01;
          end else if (cfg_r.bufen) begin
            st_nxt   = ST_BUF;
            bufc_nxt = 4'(`WDF_BUF_CONV);
          end else begin
            st_nxt = ST_RUN;
          end
        end
        ST_BUF: begin
          if (conv_tick) begin
            bufc_nxt = bufc_r - 4'h1;
            if (bufc_r == 4'h1) st_nxt = ST_RUN;
          end
        end
        ST_RUN:  st_nxt = ST_RUN;
        default: st_nxt = ST_OVH;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `WDF_CTRL_RST;
      cfg_r  <= `WDF_CTRL_RST;
      st_r   <= ST_OVH;
      ovh_r  <= 8'(`WDF_OVH_CYC - 1);
      bufc_r <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cfg_r  <= cfg_nxt;
      st_r   <= st_nxt;
      ovh_r  <= ovh_nxt;
      bufc_r <= bufc_nxt;
    end
  end

  assign run = (st_r == ST_RUN) & ~restart;

  // ****************************************
  // First stage: decimation by the ratio
  // ****************************************
  wdf_decim u_decim (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .clr        (~run),
    .ratio      (cfg_r.ratio),
    .mod_en     (mod_en & run),
    .sample     (mdat_s_r),
    .word       (dword),
    .word_valid (dvalid)
  );

  // ****************************************
  // Second stage: symmetric 69-tap average
  // ****************************************
  // Equal taps make the stage linear phase with its centre 34 words
  // back; a step needs all 69 taps refreshed before it has settled.
  assign oldest = tap_mem[ptr_r];

  always_comb begin
    ptr_nxt  = ptr_r;
    fill_nxt = fill_r;
    fsum_nxt = fsum_r;
    pub      = 1'b0;
    pub_val  = dword;
    if (~run) begin
      ptr_nxt  = 7'h00;
      fill_nxt = 7'h00;
      fsum_nxt = 23'sh000000;
    end else if (dvalid) begin
      fsum_nxt = fsum_r + 23'(dword) -
        ((fill_r == 7'(`WDF_FIR_TAPS)) ? 23'(oldest) : 23'sh000000);
      ptr_nxt  = (ptr_r == 7'(`WDF_FIR_TAPS - 1)) ? 7'h00 : ptr_r + 7'h01;
      if (fill_r != 7'(`WDF_FIR_TAPS)) fill_nxt = fill_r + 7'h01;
      if (cfg_r.low_lat) begin
        pub = 1'b1;
      end else begin
        // The word that closes the 68th period is the first one shown.
        pub     = (fill_r >= 7'(`WDF_SUPPRESS - 1));
        pub_val = wdf_norm(fsum_nxt);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (run && dvalid) tap_mem[ptr_r] <= dword;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r  <= 7'h00;
      fill_r <= 7'h00;
      fsum_r <= 23'sh000000;
    end else begin
      ptr_r  <= ptr_nxt;
      fill_r <= fill_nxt;
      fsum_r <= fsum_nxt;
    end
  end

  // ****************************************
  // Saturation flag
  // ****************************************
  always_comb begin
    sat_acc_nxt  = sat_acc_r | (mod_en & run & msat_s_r);
    sat_flag_nxt = modulator_saturation_flag;
    if (~run) begin
      sat_acc_nxt = 1'b0;
    end else if (dvalid) begin
      sat_flag_nxt = sat_acc_r;
      sat_acc_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sat_acc_r                 <= 1'b0;
      modulator_saturation_flag <= 1'b0;
    end else begin
      sat_acc_r                 <= sat_acc_nxt;
      modulator_saturation_flag <= sat_flag_nxt;
    end
  end

  // ****************************************
  // Data ready and output word
  // ****************************************
  // If a word arrives while ready is already low, ready rises for one
  // cycle first so that every word is marked by its own falling edge.
  always_comb begin
    conversion_ready_n_nxt = conversion_ready_n;
    pend_nxt = pend_r;
    pval_nxt = pval_r;
    data_nxt = data_word;
    iev      = 2'b00;
    if (~run) begin
      conversion_ready_n_nxt = 1'b1;
      pend_nxt = 1'b0;
    end else if (pub && !conversion_ready_n) begin
      conversion_ready_n_nxt = 1'b1;
      pend_nxt = 1'b1;
      pval_nxt = pub_val;
    end else if (pub || pend_r) begin
      conversion_ready_n_nxt = 1'b0;
      data_nxt = pub ? pub_val : pval_r;
      pend_nxt = 1'b0;
      iev[`WDF_IRQ_DATA] = 1'b1;
    end else if (rd_data) begin
      conversion_ready_n_nxt = 1'b1;
    end
    iev[`WDF_IRQ_SAT] = run & dvalid & sat_acc_r;
    // A new event wins over the clearing read in the same cycle.
    istat_nxt = (rd_irq ? 2'b00 : istat_r) | iev;
    imask_nxt = (acc_wr && paddr == `WDF_ADDR_IRQ_MASK) ? pwdata[1:0] : imask_r;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conversion_ready_n <= 1'b1;
      pend_r             <= 1'b0;
      pval_r             <= 16'sh0000;
      data_word          <= 16'sh0000;
      istat_r            <= `WDF_IRQ_RST;
      imask_r            <= `WDF_IRQ_RST;
      irq                <= 1'b0;
    end else begin
      conversion_ready_n <= conversion_ready_n_nxt;
      pend_r             <= pend_nxt;
      pval_r             <= pval_nxt;
      data_word          <= data_nxt;
      istat_r            <= istat_nxt;
      imask_r            <= imask_nxt;
      irq                <= |(istat_nxt & imask_nxt);
    end
  end
endmodule

// ==== test/wdf_top_props.sv ====
`include "wdf_params.svh"
module wdf_top_props
  import wdf_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter side
  input wire logic        mod_clk_o,
  input wire wdf_word_t   data_word,
  input wire logic        conversion_ready_n,
  input wire logic        modulator_saturation_flag,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Word spacing
  // ****
  // The gap counter saturates so a long idle stretch never wraps to a short gap.
  logic       rdy_r;
  logic       rdy_nxt;
  logic [8:0] gap_r;
  logic [8:0] gap_nxt;
  logic       fall;
  logic       acc;
  logic       mapped;
  assign acc = psel && penable;
  assign mapped = paddr inside {`WDF_ADDR_CTRL, `WDF_ADDR_STATUS, `WDF_ADDR_DATA,
                                `WDF_ADDR_IRQ_STAT, `WDF_ADDR_IRQ_MASK};
  assign fall = rdy_r && !conversion_ready_n;
  always_comb begin
    rdy_nxt = conversion_ready_n;
    gap_nxt = fall ? 9'h000 : gap_r + {8'h00, gap_r != 9'h1ff};
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_r <= 1'b1;
      gap_r <= 9'h1ff;
    end else begin
      rdy_r <= rdy_nxt;
      gap_r <= gap_nxt;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_word_spacing: assert property (fall |-> gap_r >= 9'h0f0)
    else $error("words closer than the shortest period");
  a_word_on_fall: assert property ($changed(data_word) |-> fall)
    else $error("data word moved without ready falling");
  a_read_clears: assert property (acc && !pwrite && paddr == `WDF_ADDR_DATA
    |=> conversion_ready_n) else $error("data read left ready low");
  a_modclk_hold: assert property ($changed(mod_clk_o) |=> $stable(mod_clk_o)[*2])
    else $error("modulator clock half too short");
  a_modclk_bound: assert property ($changed(mod_clk_o) |-> ##[1:33] $changed(mod_clk_o))
    else $error("modulator clock half too long");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr && pready)
    else $error("mapped access refused");
  a_sync_reads0: assert property (acc && !pwrite && paddr == `WDF_ADDR_CTRL
    |-> prdata[31:6] == 26'h0) else $error("control upper bits not zero");
  a_mask_quiet: assert property (acc && pwrite && paddr == `WDF_ADDR_IRQ_MASK
    && pwdata[1:0] == 2'h0 |-> ##2 !irq) else $error("irq high with mask clear");
  a_flag_settle: assert property ($changed(modulator_saturation_flag)
    |=> $stable(modulator_saturation_flag)[*8]) else $error("flag moved twice");
endmodule

// ==== test/wdf_mod_model.sv ====
module wdf_mod_model (
  // Clocks
  input wire logic        mclk,
  input wire logic        mod_clk,
  // Bench requests
  input wire logic [4:0]  level,
  input wire logic        sat_req,
  // Modulator stream
  output logic [4:0]      mod_data,
  output logic            mod_sat
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_q = 1'b0;
  initial begin
    mod_data = 5'h00;
    mod_sat = 1'b0;
  end
  // A new sample leaves only on a rising modulator clock, as a real modulator would.
  always @(posedge mclk) begin
    clk_q <= mod_clk;
    if (mod_clk && !clk_q) begin
      mod_data <= level;
      mod_sat <= sat_req;
    end
  end
endmodule

// ==== test/tb.sv ====
`include "wdf_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        sync_pin = 1'b0;
  logic        sat_req = 1'b0;
  logic [4:0]  lvl = 5'h00;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [15:0] data_word;
  logic [4:0]  mod_data;
  logic        pready, pslverr, mod_sat, mod_clk_o, rdy_n, sat_flag, irq, e;
  int          err_count = 0;
  int          samples_checked = 0;
  always #5 mclk = ~mclk;
  wdf_top dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_data(mod_data), .mod_sat(mod_sat), .sync_pin(sync_pin),
    .mod_clk_o(mod_clk_o), .data_word(data_word), .conversion_ready_n(rdy_n),
    .modulator_saturation_flag(sat_flag), .irq(irq));
  wdf_mod_model mod_u (.mclk(mclk), .mod_clk(mod_clk_o), .level(lvl), .sat_req(sat_req),
    .mod_data(mod_data), .mod_sat(mod_sat));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] near(input int c, input int x, input int t);
    near = {31'h0, c >= x - t && c <= x + t};
  endfunction
  // A modulator sample takes 7.8125 cycles at high speed, 62.5 at low speed.
  function automatic int per(input int code, input logic ls);
    per = (ls ? 2000 : 250) << code;
  endfunction
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_fall(output int c);
    logic p;
    p = rdy_n;
    c = 0;
    forever begin
      @(posedge mclk);
      #1;
      c++;
      if (p === 1'b1 && rdy_n === 1'b0) break;
      p = rdy_n;
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    test_done();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] s;
    int          c;
    int          code;
    s = 32'h2f5c83f4;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `WDF_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, q | {31'h0, e});
    // Let the restart that follows reset finish, so busy can only come from the pin.
    repeat (50) @(posedge mclk);
    apb(1'b0, `WDF_ADDR_STATUS, 32'h0);
    chk("idle before pin", 32'h0, {31'h0, q[2]});
    sync_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    sync_pin <= 1'b0;
    apb(1'b0, `WDF_ADDR_STATUS, 32'h0);
    chk("busy after pin", 32'h1, {31'h0, q[2]});
    apb(1'b1, `WDF_ADDR_IRQ_MASK, 32'h3);
    // Ratio codes 0..5 at high speed, then ratio 32 at low speed, low-latency mode.
    for (int i = 0; i < 7; i++) begin
      code = i < 6 ? i : 0;
      s = lfsr(s);
      @(posedge mclk);
      lvl <= {s[4], s[4] ? 4'h4 : 4'hc};
      apb(1'b1, `WDF_ADDR_CTRL, {26'h0, i == 6, code[2:0], 1'b1});
      wait_fall(c);
      apb(1'b0, `WDF_ADDR_DATA, 32'h0);
      chk("data sign", {31'h0, s[4]}, {q[31:16], 15'h0, q[15]});
      // The data read took three edges of the period being measured.
      wait_fall(c);
      chk("word period", 32'h1, near(c + 3, per(code, i == 6), 2));
    end
    apb(1'b1, `WDF_ADDR_CTRL, 32'h11);
    apb(1'b0, `WDF_ADDR_STATUS, 32'h0);
    chk("same cfg idle", 32'h0, {31'h0, q[2]});
    apb(1'b1, `WDF_ADDR_CTRL, 32'h01);
    apb(1'b0, `WDF_ADDR_STATUS, 32'h0);
    chk("new cfg busy", 32'h1, {31'h0, q[2]});
    wait_fall(c);
    wait_fall(c);
    @(posedge mclk);
    sat_req <= 1'b1;
    repeat (20) @(posedge mclk);
    sat_req <= 1'b0;
    wait_fall(c);
    repeat (2) @(posedge mclk);
    chk("sat flag set", 32'h1, {31'h0, sat_flag});
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, `WDF_ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 32'h3, q);
    apb(1'b0, `WDF_ADDR_IRQ_STAT, 32'h0);
    chk("irq cleared", 32'h0, q);
    repeat (2) @(posedge mclk);
    chk("irq low", 32'h0, {31'h0, irq});
    wait_fall(c);
    repeat (2) @(posedge mclk);
    chk("sat flag clear", 32'h0, {31'h0, sat_flag});
    apb(1'b1, `WDF_ADDR_IRQ_MASK, 32'h0);
    wait_fall(c);
    repeat (2) @(posedge mclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    // Wideband restart: overhead plus 68 periods of 250 cycles; buffers add 8 converter periods.
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `WDF_ADDR_CTRL, {25'h0, 1'b1, b[0], 5'h00});
      wait_fall(c);
      chk("latency", 32'h1, near(c, `WDF_OVH_CYC + `WDF_SUPPRESS * 250 + 31 * b, 8));
      apb(1'b0, `WDF_ADDR_DATA, 32'h0);
      chk("settled sign", {31'h0, lvl[4]}, {q[31:16], 15'h0, q[15]});
    end
    test_done();
  end
endmodule
bind wdf_top wdf_top_props chk_u (.mclk(mclk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mod_clk_o(mod_clk_o), .data_word(data_word),
  .conversion_ready_n(conversion_ready_n),
  .modulator_saturation_flag(modulator_saturation_flag), .irq(irq));
